// >>> free_running_timer_capture_test.sv
// Self-checking bench for the timer and capture block
`timescale 1ns/10ps
module free_running_timer_capture_test;
  // ------------------------------------------------------------
  // Signals and helpers
  // ------------------------------------------------------------
  // Short tick keeps the 1024-tick wait near 10k cycles
  localparam int TDIV = 10;
  // Start two carries below the roll so the wrap is reached in time
  localparam logic [15:0] START = 16'hf800;
  logic                    core_clk;
  logic                    resetn;
  logic [1:0]              cap_pin;
  frtc_pkg::frtc_cap_cfg_t cap_cfg;
  frtc_pkg::frtc_pit_cfg_t pit_cfg;
  logic [15:0]             frt_count;
  logic [1:0][7:0]         cap_rise;
  logic [1:0][7:0]         cap_fall;
  logic                    wrap_irq;
  logic                    ms_irq;
  logic [1:0]              cap_irq;
  logic                    pit_irq;
  int                      error_cnt;
  int                      check_count;
  int                      shf[4] = '{frtc_pkg::SLICE_SH0,
                                       frtc_pkg::SLICE_SH1,
                                       frtc_pkg::SLICE_SH2,
                                       frtc_pkg::SLICE_SH3};

  frtc_timer #(.TICK_DIV(TDIV), .START_COUNT(START)) dut_u (
    .CORE_CLK    (core_clk),
    .RESETN      (resetn),
    .CAP_PIN     (cap_pin),
    .CAP_CFG     (cap_cfg),
    .PIT_CFG     (pit_cfg),
    .FRT_COUNT   (frt_count),
    .CAP_RISE    (cap_rise),
    .CAP_FALL    (cap_fall),
    .FRT_WRAP_IRQ(wrap_irq),
    .MS_IRQ      (ms_irq),
    .CAP_IRQ     (cap_irq),
    .PIT_IRQ     (pit_irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [15:0] held(input logic r);
    return r ? {cap_rise[1], cap_rise[0]} : {cap_fall[1], cap_fall[0]};
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_tick;
    int n;
    chk("count after reset", START, frt_count);
    n = 0;
    while (frt_count === START && n < 3 * TDIV) begin
      step;
      n++;
    end
    chk("first tick", START + 16'h0001, frt_count);
    repeat (TDIV) step;
    chk("next tick", START + 16'h0002, frt_count);
    $display("test_tick done");
  endtask

  task automatic test_ms;
    int n;
    n = 0;
    while (ms_irq !== 1'b1 && n < 1100 * TDIV) begin
      step;
      n++;
    end
    chk("ms event count", START + 16'h0400, frt_count);
    chk("no wrap at ms", 16'h0000, {15'h0, wrap_irq});
    step;
    chk("ms pulse end", 16'h0000, {15'h0, ms_irq});
    $display("test_ms done");
  endtask

  task automatic test_wrap;
    int n;
    n = 0;
    while (wrap_irq !== 1'b1 && n < 1100 * TDIV) begin
      step;
      n++;
    end
    chk("wrap count", 16'h0000, frt_count);
    chk("ms at wrap", 16'h0001, {15'h0, ms_irq});
    step;
    chk("wrap pulse end", 16'h0000, {15'h0, wrap_irq});
    $display("test_wrap done");
  endtask

  // Pin and config land on one edge; capture sees the count before the next
  task automatic cap_edge(input int ch, input logic lvl, input int sh,
                          input frtc_pkg::frtc_cap_cfg_t cfg);
    logic [15:0] cnt;
    logic [15:0] keep;
    logic [1:0]  msk;
    logic [15:0] seen;
    msk = (ch == 1) ? 2'b10 : 2'b01;
    @(posedge core_clk);
    cap_cfg <= cfg;
    cap_pin <= (cap_pin & ~msk) | (lvl ? msk : 2'b00);
    #1;
    cnt = frt_count;
    keep = held(!lvl);
    step;
    seen = held(lvl);
    if (cfg.gang) chk("gang capture", cnt, seen);
    else chk("slice", {8'h00, 8'(cnt >> sh)}, {8'h00, seen[8*ch+:8]});
    chk("other edge kept", keep, held(!lvl));
    chk("capture irq", {14'h0, msk}, {14'h0, cap_irq});
    step;
    chk("capture pulse end", 16'h0000, {14'h0, cap_irq});
  endtask

  task automatic test_cap;
    frtc_pkg::frtc_cap_cfg_t c;
    for (int s = 0; s < 4; s++) begin
      c = '{rise_en: 2'b11, fall_en: 2'b11, gang: 1'b0, slice_sel: 2'(s)};
      for (int ch = 0; ch < 2; ch++) begin
        cap_edge(ch, 1'b1, shf[s], c);
        repeat (TDIV + 3) step;
        cap_edge(ch, 1'b0, shf[s], c);
      end
    end
    c = '{rise_en: 2'b01, fall_en: 2'b01, gang: 1'b1, slice_sel: 2'd0};
    cap_edge(0, 1'b1, 0, c);
    repeat (TDIV + 3) step;
    cap_edge(0, 1'b0, 0, c);
    // Gang ignores pin 1; channel 0 rising edge is masked
    @(posedge core_clk);
    cap_cfg <= '{rise_en: 2'b10, fall_en: 2'b00, gang: 1'b1, slice_sel: 2'd0};
    cap_pin <= 2'b11;
    step;
    chk("masked edge irq", 16'h0000, {14'h0, cap_irq});
    $display("test_cap done");
  endtask

  task automatic wait_pit(output int n);
    n = 0;
    do begin
      step;
      n++;
    end while (pit_irq !== 1'b1 && n < 50000);
  endtask

  task automatic pit_run(input logic [11:0] rl);
    int n;
    @(posedge core_clk);
    pit_cfg <= '{enable: 1'b1, reload: rl};
    wait_pit(n);
    wait_pit(n);
    chk("interval period", 16'((rl + 1) * TDIV), 16'(n));
    @(posedge core_clk);
    pit_cfg <= '{enable: 1'b0, reload: rl};
    $display("pit_run done");
  endtask

  initial begin
    resetn = 1'b0;
    cap_pin = 2'b00;
    cap_cfg = '0;
    pit_cfg = '0;
    error_cnt = 0;
    check_count = 0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    step;
    test_tick;
    test_ms;
    test_wrap;
    test_cap;
    pit_run(12'h000);
    pit_run(12'h005);
    end_of_test;
  end

  // Tests need about 22k cycles; three times that marks a hang
  initial begin
    repeat (66000) @(posedge core_clk);
    error_cnt++;
    end_of_test;
  end
endmodule

// >>> frtc_pkg.sv
// Package of constants and carrier types for the timer and capture block
package frtc_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MS_EVENT_US = 1024;
  localparam int MS_CARRY_BITS = $clog2(MS_EVENT_US);
  localparam int PRESC_W = $clog2(TICK_CYCLES);
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYCLES - 1);

  // ------------------------------------------------------------
  // Reset values and slice shifts
  // ------------------------------------------------------------
  localparam logic [15:0] FRT_RESET = 16'h0000;
  localparam logic [11:0] PIT_RESET = 12'h000;
  localparam logic [7:0] CAP_RESET = 8'h00;
  localparam logic [3:0] SLICE_SH0 = 4'h0;
  localparam logic [3:0] SLICE_SH1 = 4'h2;
  localparam logic [3:0] SLICE_SH2 = 4'h4;
  localparam logic [3:0] SLICE_SH3 = 4'h8;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rise_en;
    logic [1:0] fall_en;
    logic       gang;
    logic [1:0] slice_sel;
  } frtc_cap_cfg_t;

  typedef struct packed {
    logic       enable;
    logic [11:0] reload;
  } frtc_pit_cfg_t;
endpackage

// >>> frtc_timer.sv
// Free-running timer, edge capture channels and interval timer
`timescale 1ns/10ps
// Notes on behaviour
// - A 16-bit free-running counter raises a wrap request on each roll to zero.
// - A 1.024 ms periodic event is its own request, apart from the wrap.
// - A selected pin edge copies a chosen 8-bit slice of the counter.
// - Each pin has a rising-edge and a falling-edge holding register.
// - In gang mode both channels hold one 16-bit capture of the counter.
// - Each capture raises a request for its own channel, except in gang mode, where only channel 0 raises one.
// - A 12-bit interval timer raises a request each time its interval ends.
module frtc_timer #(
  parameter int          TICK_DIV    = frtc_pkg::TICK_CYCLES,
  // Start value lets a short run reach the roll to zero
  parameter logic [15:0] START_COUNT = frtc_pkg::FRT_RESET
) (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RESETN,
  input  wire logic [1:0]              CAP_PIN,
  input  wire frtc_pkg::frtc_cap_cfg_t CAP_CFG,
  input  wire frtc_pkg::frtc_pit_cfg_t PIT_CFG,
  output logic [15:0]                  FRT_COUNT,
  output logic [1:0][7:0]              CAP_RISE,
  output logic [1:0][7:0]              CAP_FALL,
  output logic                         FRT_WRAP_IRQ,
  output logic                         MS_IRQ,
  output logic [1:0]                   CAP_IRQ,
  output logic                         PIT_IRQ
);
  // ------------------------------------------------------------
  // Microsecond prescaler
  // ------------------------------------------------------------
  // Width follows the divider so any TICK_DIV of 2 or more fits the prescaler
  localparam int            PW         = $clog2(TICK_DIV);
  localparam int            DIV_LAST_I = TICK_DIV - 1;
  localparam logic [PW-1:0] DIV_LAST   = DIV_LAST_I[PW-1:0];

  logic [PW-1:0] presc_r;
  logic [PW-1:0] presc_nxt;
  logic          tick;

  assign tick = (presc_r == DIV_LAST);

  always_comb begin
    if (tick) begin
      presc_nxt = '0;
    end else begin
      presc_nxt = presc_r + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_nxt;
    end
  end

  // ------------------------------------------------------------
  // Free-running counter and its events
  // ------------------------------------------------------------
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        wrap_r;
  logic        wrap_nxt;
  logic        ms_r;
  logic        ms_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    wrap_nxt = 1'b0;
    ms_nxt   = 1'b0;
    if (tick) begin
      cnt_nxt  = cnt_r + 16'h0001;
      wrap_nxt = (cnt_r == 16'hffff);
      // Carry out of the low ten bits marks each 1024 us
      ms_nxt   = &cnt_r[frtc_pkg::MS_CARRY_BITS-1:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      cnt_r  <= START_COUNT;
      wrap_r <= 1'b0;
      ms_r   <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      wrap_r <= wrap_nxt;
      ms_r   <= ms_nxt;
    end
  end

  assign FRT_COUNT    = cnt_r;
  assign FRT_WRAP_IRQ = wrap_r;
  assign MS_IRQ       = ms_r;

  // ------------------------------------------------------------
  // Capture channels
  // ------------------------------------------------------------
  logic [1:0]      pin_prev_r;
  logic [1:0][7:0] rise_r;
  logic [1:0][7:0] rise_nxt;
  logic [1:0][7:0] fall_r;
  logic [1:0][7:0] fall_nxt;
  logic [1:0]      cirq_r;
  logic [1:0]      cirq_nxt;
  logic [1:0]      rise_hit;
  logic [1:0]      fall_hit;
  logic [3:0]      shift;
  logic [7:0]      slice;

  always_comb begin
    unique case (CAP_CFG.slice_sel)
      2'h0: shift = frtc_pkg::SLICE_SH0;
      2'h1: shift = frtc_pkg::SLICE_SH1;
      2'h2: shift = frtc_pkg::SLICE_SH2;
      2'h3: shift = frtc_pkg::SLICE_SH3;
    endcase
  end

  assign slice = 8'(cnt_r >> shift);

  always_comb begin
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    cirq_nxt = 2'h0;
    for (int i = 0; i < 2; i++) begin
      rise_hit[i] = CAP_PIN[i] & ~pin_prev_r[i] & CAP_CFG.rise_en[i];
      fall_hit[i] = ~CAP_PIN[i] & pin_prev_r[i] & CAP_CFG.fall_en[i];
    end
    if (CAP_CFG.gang) begin
      // Channel 0 pin and enables drive the full-width capture
      if (rise_hit[0]) begin
        rise_nxt[0] = cnt_r[7:0];
        rise_nxt[1] = cnt_r[15:8];
      end
      if (fall_hit[0]) begin
        fall_nxt[0] = cnt_r[7:0];
        fall_nxt[1] = cnt_r[15:8];
      end
      cirq_nxt[0] = rise_hit[0] | fall_hit[0];
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rise_hit[i]) begin
          rise_nxt[i] = slice;
        end
        if (fall_hit[i]) begin
          fall_nxt[i] = slice;
        end
        cirq_nxt[i] = rise_hit[i] | fall_hit[i];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      pin_prev_r <= 2'h0;
      rise_r     <= {2{frtc_pkg::CAP_RESET}};
      fall_r     <= {2{frtc_pkg::CAP_RESET}};
      cirq_r     <= 2'h0;
    end else begin
      pin_prev_r <= CAP_PIN;
      rise_r     <= rise_nxt;
      fall_r     <= fall_nxt;
      cirq_r     <= cirq_nxt;
    end
  end

  assign CAP_RISE = rise_r;
  assign CAP_FALL = fall_r;
  assign CAP_IRQ  = cirq_r;

  // ------------------------------------------------------------
  // Programmable interval timer
  // ------------------------------------------------------------
  logic [11:0] pit_r;
  logic [11:0] pit_nxt;
  logic        pirq_r;
  logic        pirq_nxt;

  always_comb begin
    pit_nxt  = pit_r;
    pirq_nxt = 1'b0;
    if (!PIT_CFG.enable) begin
      // Preload while idle so the first interval is full length
      pit_nxt = PIT_CFG.reload;
    end else if (tick) begin
      if (pit_r == 12'h000) begin
        pit_nxt  = PIT_CFG.reload;
        pirq_nxt = 1'b1;
      end else begin
        pit_nxt = pit_r - 12'h001;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      pit_r  <= frtc_pkg::PIT_RESET;
      pirq_r <= 1'b0;
    end else begin
      pit_r  <= pit_nxt;
      pirq_r <= pirq_nxt;
    end
  end

  assign PIT_IRQ = pirq_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  a_wrap_to_zero: assert property (
    tick && cnt_r == 16'hffff |=> FRT_WRAP_IRQ && cnt_r == 16'h0000)
    else $error("Wrap request missing at counter roll");
  a_wrap_only_roll: assert property (
    FRT_WRAP_IRQ |-> cnt_r == 16'h0000 && $past(tick))
    else $error("Wrap request without a roll");
  a_ms_event_carry: assert property (
    MS_IRQ |-> cnt_r[9:0] == 10'h000 && $past(cnt_r[9:0]) == 10'h3ff)
    else $error("Millisecond event not on ten-bit carry");
  a_tick_spacing: assert property (
    tick |=> !tick [*8])
    else $error("Microsecond tick too frequent");
  a_cap_rise_slice: assert property (
    rise_hit[1] && !CAP_CFG.gang |=> CAP_RISE[1] == $past(slice))
    else $error("Rising capture value wrong");
  a_cap_fall_hold: assert property (
    rise_hit[0] && !fall_hit[0] && !CAP_CFG.gang |=> $stable(CAP_FALL[0]))
    else $error("Falling register disturbed by rising edge");
  a_cap_gang_word: assert property (
    CAP_CFG.gang && fall_hit[0] |=>
      {CAP_FALL[1], CAP_FALL[0]} == $past(cnt_r))
    else $error("Ganged capture not full counter");
  a_cap_irq_cause: assert property (
    CAP_IRQ[0] |-> $past(rise_hit[0] || fall_hit[0]))
    else $error("Capture request without stored edge");
  a_pit_expiry: assert property (
    PIT_CFG.enable && tick && pit_r == 12'h000 |=>
      PIT_IRQ && pit_r == $past(PIT_CFG.reload))
    else $error("Interval expiry missed");
endmodule
